//--- hw/dscs_cfg.svh
`ifndef DSCS_CFG_SVH
`define DSCS_CFG_SVH
// Summary of operation
// - core: 12 periods standard, 6 doubled
// - divide-by-two stage, always running, no bypass
// - reset gives standard speed unless option
// - startup option starts doubled after reset
// - double-speed bit with all peripheral bits set changes only CPU
// - peripheral doubles when cpu doubled, bit clear
// - peripheral bit: 0 six, 1 twelve periods
// - cpu bit zero: peripheral bits ignored
// - mode change only on divided rising edge
// - uart bit only for modes 0, 2
// - register 8Fh bit layout, can down to cpu
// - clock control register resets to zero
// - reached by direct sfr address 80h-FFh
`define DSCS_REG_ADDR 8'h8F
`define DSCS_SFR_LO 8'h80
`define DSCS_REG_RESET 8'h00
`define DSCS_BIT_CPU 0
`define DSCS_BIT_T0 1
`define DSCS_BIT_T1 2
`define DSCS_BIT_T2 3
`define DSCS_BIT_UART 4
`define DSCS_BIT_PCA 5
`define DSCS_BIT_WDT 6
`define DSCS_BIT_CAN 7
`define DSCS_PHASES_STD 4'hC
`define DSCS_PHASES_DBL 4'h6
`define DSCS_NPERIPH 7
`define DSCS_BOOT_WAIT 2'h2
`endif

//--- hw/dscs_pkg.sv
package dscs_pkg;
	// per-cycle tick outputs, one per consumer
	typedef struct packed {
		logic can;
		logic wdt;
		logic counter_array;
		logic uart;
		logic t2;
		logic t1;
		logic t0;
		logic cpu;
	} dscs_ticks_t;
	// sfr direct access request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dscs_sfr_req_t;
endpackage

//--- hw/dscs_rate_gen.sv
`include "dscs_cfg.svh"
// counts oscillator periods; emits one tick per cycle of 12 or 6 periods.
// mode is taken only at a divided-clock rising edge that starts a new cycle.
module dscs_rate_gen (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// control
	input wire logic fast_req,
	input wire logic half_rise,
	// result
	output logic tick,
	output logic fast_now
);
	typedef struct packed {
		logic [3:0] cnt;
		logic fast;
		logic tick;
	} dscs_rg_state_t;
	dscs_rg_state_t st_reg, st_next;

	// a cycle ends at its full count; count only restarts at boundaries, so
	// no phase is ever cut short when the rate changes
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// latching only on the first edge of a cycle keeps every cycle whole
		if (half_rise && st_reg.cnt == 4'h0)
		begin
			st_next.fast = fast_req;
		end
		if (st_reg.cnt >= (st_reg.fast ? `DSCS_PHASES_DBL : `DSCS_PHASES_STD) - 4'h1)
		begin
			st_next.cnt = 4'h0;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
	assign fast_now = st_reg.fast;

	// eleven quiet periods, then the next tick
	sequence s_std_gap;
		!tick [*8] ##1 !tick [*3] ##1 tick;
	endsequence
	property p_period;
		@(posedge sys_clk) disable iff (!nrst)
		(tick ##1 !fast_now) |-> s_std_gap;
	endproperty
	a_period: assert property (p_period) else $error("standard cycle not 12 periods");
endmodule

//--- hw/dscs_top.sv
`include "dscs_cfg.svh"
// clock-rate select block: holds the clock control register and produces
// per-consumer cycle ticks derived from the oscillator clock sys_clk
module dscs_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// nonvolatile startup option, static pin
	input wire logic startup_double_speed_option,
	// sfr direct-access port from the cpu
	input wire dscs_pkg::dscs_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// uart mode field, from the uart
	input wire logic [1:0] uart_mode,
	// rate outputs
	output dscs_pkg::dscs_ticks_t ticks,
	output logic [7:0] clock_rate_select,
	output logic half_clk
);
	typedef struct packed {
		logic [7:0] ctl;
		logic [1:0] opt_sync;
		logic boot_done;
		logic [1:0] boot_wait;
		logic half;
		logic [7:0] rdata;
		logic hit;
	} dscs_state_t;
	dscs_state_t st_reg, st_next;

	logic [7:0] eff_fast;
	logic [7:0] tick_vec;
	logic [7:0] fast_vec;
	logic half_rise;
	logic addr_ok;

	// sfr decode only inside the direct sfr window
	assign addr_ok = (sfr_req.addr >= `DSCS_SFR_LO) && (sfr_req.addr == `DSCS_REG_ADDR);
	// divided clock rising edge happens when the half toggle goes high
	assign half_rise = !st_reg.half;

	// register, divider and strap capture
	always_comb
	begin
		st_next = st_reg;
		st_next.half = !st_reg.half;
		st_next.opt_sync = {st_reg.opt_sync[0], startup_double_speed_option};
		st_next.hit = 1'b0;
		if (!st_reg.boot_done)
		begin
			// strap is read only once both sync stages hold it, never under reset
			if (st_reg.boot_wait == `DSCS_BOOT_WAIT)
			begin
				st_next.boot_done = 1'b1;
				st_next.ctl[`DSCS_BIT_CPU] = st_reg.opt_sync[1];
			end
			else
			begin
				st_next.boot_wait = st_reg.boot_wait + 2'h1;
			end
		end
		if (sfr_req.wr && addr_ok)
		begin
			st_next.ctl = sfr_req.wdata;
			st_next.hit = 1'b1;
		end
		if (sfr_req.rd && addr_ok)
		begin
			st_next.rdata = st_reg.ctl;
			st_next.hit = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
			st_reg.ctl <= `DSCS_REG_RESET;
		end
		else
			st_reg <= st_next;
	end

	// effective doubling: cpu bit gates every peripheral bit
	always_comb
	begin
		eff_fast = 8'h00;
		eff_fast[`DSCS_BIT_CPU] = st_reg.ctl[`DSCS_BIT_CPU];
		for (int i = 1; i < 8; i++)
			eff_fast[i] = st_reg.ctl[`DSCS_BIT_CPU] && !st_reg.ctl[i];
		// uart modes 1 and 3 follow their own timing, never doubled here
		if (uart_mode != 2'b00 && uart_mode != 2'b10)
			eff_fast[`DSCS_BIT_UART] = 1'b0;
	end

	// one rate generator per consumer
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : gen_rate
			dscs_rate_gen u_rg (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.fast_req(eff_fast[g]),
				.half_rise(half_rise),
				.tick(tick_vec[g]),
				.fast_now(fast_vec[g])
			);

			// a standard cycle: eleven quiet periods, then the next tick
			sequence s_std_len;
				!tick_vec[g] [*8] ##1 !tick_vec[g] [*3] ##1 tick_vec[g];
			endsequence
			// a doubled cycle: five quiet periods, then the next tick
			sequence s_dbl_len;
				!tick_vec[g] [*5] ##1 tick_vec[g];
			endsequence
			property p_cons_std;
				@(posedge sys_clk) disable iff (!nrst)
				(tick_vec[g] ##1 !fast_vec[g]) |-> s_std_len;
			endproperty
			a_cons_std: assert property (p_cons_std) else $error("consumer cycle not 12");
			property p_cons_dbl;
				@(posedge sys_clk) disable iff (!nrst)
				(tick_vec[g] ##1 fast_vec[g]) |-> s_dbl_len;
			endproperty
			a_cons_dbl: assert property (p_cons_dbl) else $error("consumer cycle not 6");
			// the latched rate is the one requested at the latch edge
			property p_cons_latch;
				@(posedge sys_clk) disable iff (!nrst)
				$changed(fast_vec[g]) |-> (fast_vec[g] == $past(eff_fast[g]));
			endproperty
			a_cons_latch: assert property (p_cons_latch) else $error("wrong rate latched");
			// a tick lasts a single period
			property p_tick_pulse;
				@(posedge sys_clk) disable iff (!nrst)
				tick_vec[g] |=> !tick_vec[g];
			endproperty
			a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one");
		end
	endgenerate

	assign ticks = dscs_pkg::dscs_ticks_t'(tick_vec);
	assign clock_rate_select = st_reg.ctl;
	assign sfr_rdata = st_reg.rdata;
	assign sfr_hit = st_reg.hit;
	assign half_clk = st_reg.half;

	// a write lands in the register one edge later
	property p_reg_write;
		@(posedge sys_clk) disable iff (!nrst)
		(sfr_req.wr && sfr_req.addr == `DSCS_REG_ADDR) |=> (clock_rate_select == $past(sfr_req.wdata));
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("register write lost");

	// standard cpu: no peripheral may double
	property p_std_ignore;
		@(posedge sys_clk) disable iff (!nrst)
		!clock_rate_select[`DSCS_BIT_CPU] |-> (eff_fast == 8'h00);
	endproperty
	a_std_ignore: assert property (p_std_ignore) else $error("peripheral doubled in standard");

	// doubled cpu with a cleared timer 0 bit doubles timer 0
	property p_periph;
		@(posedge sys_clk) disable iff (!nrst)
		(clock_rate_select[0] && !clock_rate_select[`DSCS_BIT_T0]) |-> eff_fast[`DSCS_BIT_T0];
	endproperty
	a_periph: assert property (p_periph) else $error("timer0 not doubled");

	// cpu bit and all peripheral bits set: only the cpu doubles
	property p_cpu_only;
		@(posedge sys_clk) disable iff (!nrst)
		(clock_rate_select == 8'hFF) |-> (eff_fast == 8'h01);
	endproperty
	a_cpu_only: assert property (p_cpu_only) else $error("bit switched peripheral");

	// uart timing of mode 1 is never doubled here
	property p_uart;
		@(posedge sys_clk) disable iff (!nrst)
		(uart_mode == 2'b01) |-> !eff_fast[`DSCS_BIT_UART];
	endproperty
	a_uart: assert property (p_uart) else $error("uart mode 1 doubled");

	// a rate change follows a divided-clock rising edge
	property p_sync;
		@(posedge sys_clk) disable iff (!nrst)
		$changed(fast_vec[0]) |-> $past(half_rise);
	endproperty
	a_sync: assert property (p_sync) else $error("mode change off divided edge");

	// the divided clock falls after every high period
	property p_div;
		@(posedge sys_clk) disable iff (!nrst)
		half_clk |=> !half_clk;
	endproperty
	a_div: assert property (p_div) else $error("divider stalled");

	// doubled cpu: five quiet periods, then the next tick
	sequence s_dbl_cpu;
		!ticks.cpu [*5] ##1 ticks.cpu;
	endsequence
	property p_dbl;
		@(posedge sys_clk) disable iff (!nrst)
		(ticks.cpu ##1 fast_vec[0]) |-> s_dbl_cpu;
	endproperty
	a_dbl: assert property (p_dbl) else $error("double cycle not 6 periods");

	// a read returns what the register held at the request edge
	property p_reg_read;
		@(posedge sys_clk) disable iff (!nrst)
		(sfr_req.rd && sfr_req.addr == `DSCS_REG_ADDR) |=> sfr_rdata == $past(clock_rate_select);
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("register read wrong");

	// read data stands until the next read of the register
	property p_rdata_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!(sfr_req.rd && sfr_req.addr == `DSCS_REG_ADDR) |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	// an access to the register answers with a hit
	property p_hit;
		@(posedge sys_clk) disable iff (!nrst)
		((sfr_req.wr || sfr_req.rd) && sfr_req.addr == `DSCS_REG_ADDR) |=> sfr_hit;
	endproperty
	a_hit: assert property (p_hit) else $error("register access without hit");

	// any other address gives no hit
	property p_no_hit;
		@(posedge sys_clk) disable iff (!nrst)
		!((sfr_req.wr || sfr_req.rd) && sfr_req.addr == `DSCS_REG_ADDR) |=> !sfr_hit;
	endproperty
	a_no_hit: assert property (p_no_hit) else $error("hit on foreign address");

	// addresses below the sfr window never reach the register
	property p_window;
		@(posedge sys_clk) disable iff (!nrst)
		(sfr_req.addr < `DSCS_SFR_LO) |=> !sfr_hit;
	endproperty
	a_window: assert property (p_window) else $error("hit outside sfr window");

	// once booted, only a write changes the register
	property p_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(st_reg.boot_done && !(sfr_req.wr && sfr_req.addr == `DSCS_REG_ADDR))
			|=> $stable(clock_rate_select);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write");

	// the boot edge copies the synchronised strap into the cpu bit
	property p_boot;
		@(posedge sys_clk) disable iff (!nrst)
		($rose(st_reg.boot_done) && !$past(sfr_req.wr))
			|-> (clock_rate_select[`DSCS_BIT_CPU] == $past(st_reg.opt_sync[1]));
	endproperty
	a_boot: assert property (p_boot) else $error("startup option not applied");

	// a set timer 1 bit keeps timer 1 at the standard rate
	property p_periph_slow;
		@(posedge sys_clk) disable iff (!nrst)
		clock_rate_select[`DSCS_BIT_T1] |-> !eff_fast[`DSCS_BIT_T1];
	endproperty
	a_periph_slow: assert property (p_periph_slow) else $error("timer1 doubled");

	// doubled cpu with a cleared watchdog bit doubles the watchdog
	property p_wdt_dbl;
		@(posedge sys_clk) disable iff (!nrst)
		(clock_rate_select[`DSCS_BIT_CPU] && !clock_rate_select[`DSCS_BIT_WDT])
			|-> eff_fast[`DSCS_BIT_WDT];
	endproperty
	a_wdt_dbl: assert property (p_wdt_dbl) else $error("watchdog not doubled");

	// a set can bit keeps the can controller at the standard rate
	property p_can_slow;
		@(posedge sys_clk) disable iff (!nrst)
		clock_rate_select[`DSCS_BIT_CAN] |-> !eff_fast[`DSCS_BIT_CAN];
	endproperty
	a_can_slow: assert property (p_can_slow) else $error("can doubled");

	// uart modes 0 and 2 double with a cleared uart bit
	property p_uart_dbl;
		@(posedge sys_clk) disable iff (!nrst)
		(clock_rate_select[`DSCS_BIT_CPU] && !clock_rate_select[`DSCS_BIT_UART] && !uart_mode[0])
			|-> eff_fast[`DSCS_BIT_UART];
	endproperty
	a_uart_dbl: assert property (p_uart_dbl) else $error("uart mode 0 or 2 not doubled");

	// the cpu rate follows the cpu bit alone
	property p_cpu_ctl;
		@(posedge sys_clk) disable iff (!nrst)
		eff_fast[`DSCS_BIT_CPU] == clock_rate_select[`DSCS_BIT_CPU];
	endproperty
	a_cpu_ctl: assert property (p_cpu_ctl) else $error("cpu rate not from cpu bit");

	// the divided clock rises after every low period
	property p_div_rise;
		@(posedge sys_clk) disable iff (!nrst)
		!half_clk |=> half_clk;
	endproperty
	a_div_rise: assert property (p_div_rise) else $error("divider stuck low");

	// the cpu rate only changes where a cycle has just ended
	property p_bound;
		@(posedge sys_clk) disable iff (!nrst)
		$changed(fast_vec[0]) |-> $past(ticks.cpu);
	endproperty
	a_bound: assert property (p_bound) else $error("rate changed inside a cycle");
endmodule

//--- testbench/dscs_osc_model.sv
// free-running oscillator seen at the oscillator input pin, 125 MHz
module dscs_osc_model (
	// clock
	output logic sys_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// crystal runs free, so it never stops between cycles
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
endmodule

//--- testbench/tb_dscs_top.sv
module tb_dscs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, nrst, strap, hit, hc;
	logic [1:0] um;
	logic [7:0] rd, crs, n, v;
	dscs_pkg::dscs_sfr_req_t rq;
	dscs_pkg::dscs_ticks_t tk;
	int num_errors, comparisons;
	logic [7:0] v_list [6] = '{8'h00, 8'h01, 8'hFF, 8'hFE, 8'h55, 8'hAA};
	dscs_osc_model i_dscs_osc_model (.sys_clk(sys_clk));
	dscs_top i_dscs_top (.sys_clk(sys_clk), .nrst(nrst), .startup_double_speed_option(strap),
		.sfr_req(rq), .sfr_rdata(rd), .sfr_hit(hit), .uart_mode(um), .ticks(tk),
		.clock_rate_select(crs), .half_clk(hc));
	task summarize;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one-cycle request pulse, answer looked at one cycle later
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		rq = '{addr: a, wdata: d, wr: w, rd: !w};
		@(negedge sys_clk);
		rq = '0;
	endtask
	// spacing of a tick; early gaps skipped as the old cycle length may finish first
	task gap(input int b);
		int c;
		c = 0;
		repeat (4)
		begin
			c = 0;
			do
			begin
				@(negedge sys_clk);
				c++;
			end while (tk[b] !== 1'b1 && c < 40);
		end
		n = c[7:0];
	endtask
	task run(input logic [7:0] x);
		logic [7:0] e;
		acc(1'b1, 8'h8F, x);
		chk({7'h00, hit}, 8'h01);
		chk(crs, x);
		acc(1'b0, 8'h8F, 8'h00);
		chk(rd, x);
		for (int b = 0; b < 8; b++)
		begin
			if (!x[0])
				e = 8'h0C;
			else if (b == 0)
				e = 8'h06;
			else if (b == 4 && um[0])
				e = 8'h0C;
			else
				e = x[b] ? 8'h0C : 8'h06;
			gap(b);
			chk(n, e);
		end
	endtask
	task boot(input logic s);
		nrst = 1'b0;
		strap = s;
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask
	// cut a hang short well past the expected run time
	initial
	begin
		#200us;
		num_errors++;
		summarize;
	end
	initial
	begin
		num_errors = 0;
		comparisons = 0;
		um = 2'h0;
		rq = '0;
		boot(1'b0);
		chk(crs, 8'h00);
		gap(0);
		chk(n, 8'h0C);
		v[0] = hc;
		@(negedge sys_clk);
		chk({7'h00, hc}, {7'h00, !v[0]});
		foreach (v_list[i])
			run(v_list[i]);
		for (int m = 0; m < 4; m++)
		begin
			um = m[1:0];
			run(8'h01);
		end
		// other addresses, in and below the sfr window, must neither hit nor disturb the register
		acc(1'b1, 8'h8E, 8'hFE);
		chk({7'h00, hit}, 8'h00);
		chk(crs, 8'h01);
		acc(1'b0, 8'h0F, 8'h00);
		chk({7'h00, hit}, 8'h00);
		boot(1'b1);
		chk(crs, 8'h01);
		gap(0);
		chk(n, 8'h06);
		summarize;
	end
endmodule
